// File: xps_pkg.sv
// Shared constants and types for the crosspoint switch controller
`default_nettype none
package xps_pkg;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam int ROWS = 12;
  localparam int COLS = 8;
  localparam int NSW = 96;

  // ---------------------------------------------------------------
  // Bus framing
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_HI = 4'hE;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;

  // ---------------------------------------------------------------
  // Command field positions (16-bit command after the address byte)
  // ---------------------------------------------------------------
  localparam int CMD_ON_BIT = 15;
  localparam int ROW_HI = 14;
  localparam int ROW_LO = 11;
  localparam int COL_HI = 10;
  localparam int COL_LO = 8;
  localparam int LOAD_BIT = 0;

  // ---------------------------------------------------------------
  // Row code decode
  // ---------------------------------------------------------------
  localparam logic [3:0] ROW_GAP_LO = 4'h6;
  localparam logic [3:0] ROW_UP_LO = 4'h8;
  localparam logic [3:0] ROW_UP_HI = 4'hD;
  localparam logic [3:0] ROW_SHIFT = 4'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACKA = 3'h2,
    ST_WDAT = 3'h3,
    ST_ACKW = 3'h4,
    ST_RDAT = 3'h5,
    ST_ACKR = 3'h6,
    ST_SKIP = 3'h7
  } xps_state_t;

  typedef struct packed {
    logic on;
    logic [3:0] row;
    logic [2:0] col;
    logic load;
  } xps_cmd_t;

  typedef struct packed {
    logic scl;
    logic sda;
    logic swReset_b;
    logic [2:0] addrSel;
  } xps_pins_t;

  typedef struct packed {
    xps_state_t st;
    logic [3:0] bitCnt;
    logic [7:0] sh;
    logic [7:0] hiByte;
    logic byteIdx;
    logic rw;
    logic nack;
    logic sdaOe;
    logic sdaOut;
    logic sclPrev;
    logic sdaPrev;
    logic cmdValid;
    xps_cmd_t cmd;
    logic [3:0] rbRow;
  } xps_ctl_t;

  // Row code is usable (codes 6,7,14,15 are reserved)
  function automatic logic rowValid(input logic [3:0] code);
    rowValid = (code < ROW_GAP_LO) || ((code >= ROW_UP_LO) && (code <= ROW_UP_HI));
  endfunction : rowValid

  // Row code to row line index 0..11
  function automatic logic [3:0] rowIndex(input logic [3:0] code);
    rowIndex = (code < ROW_GAP_LO) ? code : 4'(code - ROW_SHIFT);
  endfunction : rowIndex

endpackage : xps_pkg
`default_nettype wire

// File: xps_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module xps_sync #(
  parameter int W = 6
) (
  input wire logic clock,          // System clock
  input wire logic rst_b,          // Async reset, active low
  input wire logic clkEn,          // Clock enable
  input wire logic [W-1:0] din,    // Raw pin levels
  output logic [W-1:0] dout        // Filtered levels
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } xps_sync_st_t;

  xps_sync_st_t s_r;
  xps_sync_st_t s_nxt;

  // Output follows once the second and third stages agree
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.s1 = din;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int i = 0; i < W; i++)
    begin
      if (s_r.s2[i] == s_r.s3[i])
      begin
        s_nxt.q[i] = s_r.s3[i];
      end
    end
  end

  // State register, idles high like the bus
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '1;
    end
    else if (clkEn)
    begin
      s_r <= s_nxt;
    end
  end

  assign dout = s_r.q;

endmodule : xps_sync
`default_nettype wire

// File: xps_array.sv
// Pending and live switch state of the 12 x 8 array
`default_nettype none
module xps_array (
  input wire logic clock,               // System clock
  input wire logic rst_b,               // Power-on reset, active low
  input wire logic clkEn,               // Clock enable
  input wire logic clr_b,               // Synced reset pin, active low
  input wire logic cmdValid,            // One-cycle command strobe
  input wire xps_pkg::xps_cmd_t cmd,    // Decoded command
  input wire logic [3:0] rbRow,         // Row code for readback
  output logic [xps_pkg::NSW-1:0] live, // Switch closed flags
  output logic [7:0] rbByte             // Columns of readback row
);

  typedef struct packed {
    logic [xps_pkg::NSW-1:0] pend;
    logic [xps_pkg::NSW-1:0] live;
  } xps_arr_t;

  xps_arr_t s_r;
  xps_arr_t s_nxt;
  logic [6:0] idx;

  // Flat switch number, row-major
  function automatic logic [6:0] swIdx(input logic [3:0] code, input logic [2:0] col);
    swIdx = 7'(xps_pkg::rowIndex(code) * xps_pkg::COLS) + 7'(col);
  endfunction : swIdx

  assign idx = swIdx(cmd.row, cmd.col);

  // Reset pin wins, then store and optional load
  always_comb
  begin
    s_nxt = s_r;
    if (!clr_b)
    begin
      s_nxt = '0;
    end
    else if (cmdValid)
    begin
      s_nxt.pend[idx] = cmd.on;
      if (cmd.load)
      begin
        s_nxt.live = s_nxt.pend;
      end
    end
  end

  // State register, all open at power-on
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
    end
    else if (clkEn)
    begin
      s_r <= s_nxt;
    end
  end

  assign live = s_r.live;
  assign rbByte = s_r.live[swIdx(rbRow, 3'h0) +: 8];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_pin_clear: assert property (clkEn && !clr_b |=> s_r.live == '0 && s_r.pend == '0)
    else $error("reset pin did not clear the array");
  a_latched_hold: assert property (clkEn && clr_b && cmdValid && !cmd.load |=> $stable(s_r.live))
    else $error("latched word changed a switch");
  a_load_apply: assert property (clkEn && clr_b && cmdValid && cmd.load
    |=> s_r.live == s_r.pend && s_r.live[$past(idx)] == $past(cmd.on))
    else $error("load word did not apply pending state");
  a_single_bit: assert property (clkEn && clr_b && cmdValid
    |=> ((s_r.pend ^ $past(s_r.pend)) & ~(96'h1 << $past(idx))) == 96'h0)
    else $error("command touched other switches");

endmodule : xps_array
`default_nettype wire

// File: xps_ctrl.sv
// Two-wire slave controller for the 12 x 8 crosspoint array
//
// How it works
// - Slave address is 1110 followed by the three address select pins.
// - Twelve rows by eight columns, every crossing stored independently.
// - Reset pin low opens all 96 switches and clears the registers.
// - Power-on reset opens every switch; pin samples reset high, other registers zero.
// - Word with load flag 1 applies switch state once fully received.
// - Load flag 0 only stores; a later flag 1 applies all pending.
// - Master can read back switch states at standard and fast speeds.
// - Device is slave only; never drives the clock, samples master clock.
// - Standard and fast speeds always; high speed only on special variant.
// - After start, shift eight bits MSB first: address then direction.
// - Match: pull data low in ninth pulse; mismatch: stay idle until start.
// - Direction 1 is a read, direction 0 is a write.
// - Byte is nine pulses: eight data bits then receiver acknowledge.
// - Data changes only while clock low, steady while clock high.
// - Write is address byte plus two command bytes, 24 bits.
// - Bit 15 state, 14..11 row, 10..8 column, bit 0 load flag.
`default_nettype none
module xps_ctrl (
  input wire logic clock,                    // System clock, 20 MHz
  input wire logic rst_b,                    // Power-on reset, active low
  input wire logic clkEn,                    // Clock enable
  input wire logic sclPin,                   // Serial clock pin level
  input wire logic sdaPin,                   // Serial data pin level
  output logic sdaOut,                       // Serial data drive level
  output logic sdaOe,                        // Serial data drive enable
  input wire logic [2:0] addrSelPin,         // Address select pins
  input wire logic swResetPin_b,             // Switch reset pin, active low
  output logic [xps_pkg::NSW-1:0] swState    // Switch closed flags
);

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  xps_pkg::xps_pins_t ps;
  xps_pkg::xps_pins_t rawPins;

  // Serial clock is only ever sampled, never driven
  assign rawPins = {sclPin, sdaPin, swResetPin_b, addrSelPin};

  // Oversampling at 20 MHz covers standard and fast speeds
  xps_sync #(
    .W(6)
  ) u_sync (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .din(rawPins),
    .dout(ps)
  );

  // ---------------------------------------------------------------
  // Switch array
  // ---------------------------------------------------------------
  xps_pkg::xps_ctl_t s_r;
  xps_pkg::xps_ctl_t s_nxt;
  logic [7:0] rbByte;

  xps_array u_array (
    .clock(clock),
    .rst_b(rst_b),
    .clkEn(clkEn),
    .clr_b(ps.swReset_b),
    .cmdValid(s_r.cmdValid),
    .cmd(s_r.cmd),
    .rbRow(s_r.rbRow),
    .live(swState),
    .rbByte(rbByte)
  );

  // ---------------------------------------------------------------
  // Bus condition detection
  // ---------------------------------------------------------------
  logic startCond;
  logic stopCond;
  logic sclRise;
  logic sclFall;
  logic addrHit;
  logic [15:0] word;

  // Start and stop need the clock high on both samples
  assign startCond = ps.scl && s_r.sclPrev && s_r.sdaPrev && !ps.sda;
  assign stopCond = ps.scl && s_r.sclPrev && !s_r.sdaPrev && ps.sda;
  assign sclRise = ps.scl && !s_r.sclPrev;
  assign sclFall = !ps.scl && s_r.sclPrev;
  // High-speed master codes never match, so they are ignored
  assign addrHit = s_r.sh[7:1] == {xps_pkg::ADDR_HI, ps.addrSel};
  assign word = {s_r.hiByte, s_r.sh};

  // ---------------------------------------------------------------
  // Protocol state machine
  // ---------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.cmdValid = 1'b0;
    s_nxt.sdaOut = 1'b0;
    s_nxt.sclPrev = ps.scl;
    s_nxt.sdaPrev = ps.sda;
    if (startCond)
    begin
      s_nxt.st = xps_pkg::ST_ADDR;
      s_nxt.bitCnt = xps_pkg::CNT_ZERO;
      s_nxt.sdaOe = 1'b0;
    end
    else if (stopCond)
    begin
      s_nxt.st = xps_pkg::ST_IDLE;
      s_nxt.sdaOe = 1'b0;
    end
    else if (sclRise)
    begin
      // Sample on the rising clock edge
      unique case (s_r.st)
        xps_pkg::ST_ADDR, xps_pkg::ST_WDAT:
        begin
          s_nxt.sh = {s_r.sh[6:0], ps.sda};
          s_nxt.bitCnt = s_r.bitCnt + xps_pkg::CNT_ONE;
        end
        xps_pkg::ST_RDAT:
        begin
          s_nxt.bitCnt = s_r.bitCnt + xps_pkg::CNT_ONE;
        end
        xps_pkg::ST_ACKR:
        begin
          s_nxt.nack = ps.sda;
        end
        xps_pkg::ST_IDLE, xps_pkg::ST_ACKA, xps_pkg::ST_ACKW, xps_pkg::ST_SKIP:
        begin
        end
      endcase
    end
    else if (sclFall)
    begin
      // Drive changes only on the falling clock edge
      unique case (s_r.st)
        xps_pkg::ST_ADDR:
        begin
          if (s_r.bitCnt == xps_pkg::BIT_LAST)
          begin
            if (addrHit)
            begin
              s_nxt.st = xps_pkg::ST_ACKA;
              s_nxt.rw = s_r.sh[0];
              s_nxt.sdaOe = 1'b1;
            end
            else
            begin
              s_nxt.st = xps_pkg::ST_SKIP;
            end
          end
        end
        xps_pkg::ST_WDAT:
        begin
          if (s_r.bitCnt == xps_pkg::BIT_LAST)
          begin
            s_nxt.st = xps_pkg::ST_ACKW;
            s_nxt.sdaOe = 1'b1;
            s_nxt.byteIdx = !s_r.byteIdx;
            if (!s_r.byteIdx)
            begin
              s_nxt.hiByte = s_r.sh;
            end
            else if (xps_pkg::rowValid(word[xps_pkg::ROW_HI:xps_pkg::ROW_LO]))
            begin
              s_nxt.cmdValid = 1'b1;
              s_nxt.cmd.on = word[xps_pkg::CMD_ON_BIT];
              s_nxt.cmd.row = word[xps_pkg::ROW_HI:xps_pkg::ROW_LO];
              s_nxt.cmd.col = word[xps_pkg::COL_HI:xps_pkg::COL_LO];
              s_nxt.cmd.load = word[xps_pkg::LOAD_BIT];
              s_nxt.rbRow = word[xps_pkg::ROW_HI:xps_pkg::ROW_LO];
            end
          end
        end
        xps_pkg::ST_ACKA:
        begin
          s_nxt.bitCnt = xps_pkg::CNT_ZERO;
          s_nxt.byteIdx = 1'b0;
          if (s_r.rw)
          begin
            s_nxt.st = xps_pkg::ST_RDAT;
            s_nxt.sh = rbByte;
            s_nxt.sdaOe = !rbByte[7];
          end
          else
          begin
            s_nxt.st = xps_pkg::ST_WDAT;
            s_nxt.sdaOe = 1'b0;
          end
        end
        xps_pkg::ST_ACKW:
        begin
          s_nxt.st = xps_pkg::ST_WDAT;
          s_nxt.bitCnt = xps_pkg::CNT_ZERO;
          s_nxt.sdaOe = 1'b0;
        end
        xps_pkg::ST_RDAT:
        begin
          if (s_r.bitCnt == xps_pkg::BIT_LAST)
          begin
            s_nxt.st = xps_pkg::ST_ACKR;
            s_nxt.sdaOe = 1'b0;
          end
          else
          begin
            s_nxt.sh = {s_r.sh[6:0], 1'b0};
            s_nxt.sdaOe = !s_r.sh[6];
          end
        end
        xps_pkg::ST_ACKR:
        begin
          if (s_r.nack)
          begin
            s_nxt.st = xps_pkg::ST_SKIP;
          end
          else
          begin
            s_nxt.st = xps_pkg::ST_RDAT;
            s_nxt.sh = rbByte;
            s_nxt.sdaOe = !rbByte[7];
            s_nxt.bitCnt = xps_pkg::CNT_ZERO;
          end
        end
        xps_pkg::ST_IDLE, xps_pkg::ST_SKIP:
        begin
        end
      endcase
    end
  end

  // State register, idle and released at power-on
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '{st: xps_pkg::ST_IDLE, sclPrev: 1'b1, sdaPrev: 1'b1, default: '0};
    end
    else if (clkEn)
    begin
      s_r <= s_nxt;
    end
  end

  assign sdaOe = s_r.sdaOe;
  assign sdaOut = s_r.sdaOut;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  a_start_to_addr: assert property (clkEn && startCond |=> s_r.st == xps_pkg::ST_ADDR && !s_r.sdaOe)
    else $error("start did not open address phase");
  a_stop_release: assert property (clkEn && stopCond |=> s_r.st == xps_pkg::ST_IDLE && !s_r.sdaOe)
    else $error("stop did not release the bus");
  a_addr_ack: assert property (clkEn && sclFall && !startCond && s_r.st == xps_pkg::ST_ADDR
    && s_r.bitCnt == xps_pkg::BIT_LAST && addrHit |=> s_r.sdaOe && s_r.st == xps_pkg::ST_ACKA)
    else $error("matching address not acknowledged");
  a_skip_silent: assert property (s_r.st == xps_pkg::ST_SKIP |-> !s_r.sdaOe)
    else $error("driving data while not addressed");
  a_read_dir: assert property (clkEn && sclFall && !stopCond && s_r.st == xps_pkg::ST_ACKA
    |=> s_r.st == ($past(s_r.rw) ? xps_pkg::ST_RDAT : xps_pkg::ST_WDAT))
    else $error("direction bit not honoured");
  a_bit_bound: assert property (s_r.bitCnt <= xps_pkg::BIT_LAST)
    else $error("more than eight data bits in a byte");
  a_drive_clk_low: assert property ($rose(s_r.sdaOe) |-> !s_r.sclPrev)
    else $error("data drive changed while clock high");
  a_reserved_drop: assert property (s_r.cmdValid |-> xps_pkg::rowValid(s_r.cmd.row))
    else $error("reserved row code reached the array");
  a_cmd_pulse: assert property (s_r.cmdValid && clkEn |=> !s_r.cmdValid)
    else $error("command strobe longer than one cycle");
  a_release_low: assert property ($fell(s_r.sdaOe) |-> !s_r.sclPrev)
    else $error("data release while clock high");
  a_addr_miss: assert property (clkEn && sclFall && s_r.st == xps_pkg::ST_ADDR
    && s_r.bitCnt == xps_pkg::BIT_LAST && !addrHit |=> s_r.st == xps_pkg::ST_SKIP && !s_r.sdaOe)
    else $error("foreign address not ignored");
  a_read_release: assert property (clkEn && sclFall && s_r.st == xps_pkg::ST_RDAT
    && s_r.bitCnt == xps_pkg::BIT_LAST |=> s_r.st == xps_pkg::ST_ACKR && !s_r.sdaOe)
    else $error("read byte not followed by master acknowledge slot");
  a_ack_stand: assert property (clkEn && s_r.st == xps_pkg::ST_ACKW && !sclFall
    && !startCond && !stopCond |=> s_r.sdaOe)
    else $error("write acknowledge dropped early");

  // ---------------------------------------------------------------
  // Cover points
  // ---------------------------------------------------------------
  c_read_more: cover property (s_r.st == xps_pkg::ST_ACKR && !s_r.nack && sclFall);
  c_write_load: cover property (s_r.cmdValid && s_r.cmd.load);
  c_write_latch: cover property (s_r.cmdValid && !s_r.cmd.load);
  c_read_byte: cover property (s_r.st == xps_pkg::ST_ACKR);
  c_mismatch: cover property (s_r.st == xps_pkg::ST_SKIP);

endmodule : xps_ctrl
`default_nettype wire

// File: xps_master.sv
// Two-wire bus master model for the crosspoint switch controller
`default_nettype none
module xps_master (
  input wire logic clock,   // System clock, pacing only
  input wire logic sdaWire, // Resolved data wire
  output logic sclPin,      // Serial clock, idle high
  output logic sdaLow       // High pulls the data wire low
);
  timeunit 1ns;
  timeprecision 1ns;

  // Bus idle: both lines released
  initial
  begin
    sclPin = 1'b1;
    sdaLow = 1'b0;
  end

  // Step to just after a system clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  // One bit: six ticks low leave room for the slave's turnaround, two high
  task automatic bitx(input logic b, output logic s);
    sdaLow = !b;
    tick(5);
    sclPin = 1'b1;
    tick(1);
    s = sdaWire;
    tick(1);
    sclPin = 1'b0;
    tick(1);
  endtask : bitx

  // Start or repeated start: data falls while clock high
  task automatic start();
    sdaLow = 1'b0;
    tick(3);
    sclPin = 1'b1;
    tick(4);
    sdaLow = 1'b1;
    tick(4);
    sclPin = 1'b0;
    tick(1);
  endtask : start

  // Stop: data rises while clock high, after the last pulse
  task automatic stop();
    sdaLow = 1'b1;
    tick(5);
    sclPin = 1'b1;
    tick(4);
    sdaLow = 1'b0;
    tick(4);
  endtask : stop

  // Nine pulses: eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(a, k);
  endtask : xfer
endmodule : xps_master
`default_nettype wire

// File: xps_ctrl_test.sv
// Self-checking bench for the crosspoint switch controller
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module xps_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock, rst_b, clkEn, sclPin, sdaOut, sdaOe, swResetPin_b, mLow, sdaWire;
  logic [2:0] addrSelPin;
  logic [95:0] swState, pend, live, obs;
  logic [95:0] expQ[$];
  logic [95:0] expV;
  logic [3:0] rbCode;
  int failures = 0;
  int cmp_count = 0;
  event obsEvt;

  // Open-drain data wire with pull-up
  assign sdaWire = !(mLow || (sdaOe && !sdaOut));

  xps_ctrl u_dut (.clock(clock), .rst_b(rst_b), .clkEn(clkEn), .sclPin(sclPin), .sdaPin(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .addrSelPin(addrSelPin), .swResetPin_b(swResetPin_b), .swState(swState));
  xps_master u_m (.clock(clock), .sdaWire(sdaWire), .sclPin(sclPin), .sdaLow(mLow));

  // 20 MHz system clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Flat switch index of a row code and column
  function automatic int swIdx(input logic [3:0] r, input logic [2:0] c);
    return ((r < 4'h6) ? int'(r) : int'(r) - 2) * 8 + int'(c);
  endfunction : swIdx

  // Reference pending and live state
  function automatic void model(input logic [15:0] w);
    if (w[14:11] < 4'h6 || (w[14:11] >= 4'h8 && w[14:11] <= 4'hD))
    begin
      pend[swIdx(w[14:11], w[10:8])] = w[15];
      rbCode = w[14:11];
      if (w[0])
        live = pend;
    end
  endfunction : model

  // Queue an expectation and hand the observed value to the checker
  task automatic note(input logic [95:0] e, input logic [95:0] g);
    expQ.push_back(e);
    obs = g;
    ->obsEvt;
    #1;
  endtask : note

  // Idle gap with random clock-enable stalls, then settle
  task automatic gap();
    repeat (6)
    begin
      clkEn = 1'($urandom);
      u_m.tick(1);
    end
    clkEn = 1'b1;
    u_m.tick(6);
  endtask : gap

  // Write transfer carrying whole command words
  task automatic wr(input logic [15:0] w[$]);
    logic [7:0] r;
    logic k;
    u_m.start();
    u_m.xfer({4'hE, addrSelPin, 1'b0}, 1'b1, r, k);
    note(96'h0, {95'h0, k});
    foreach (w[i])
    begin
      u_m.xfer(w[i][15:8], 1'b1, r, k);
      note(96'h0, {95'h0, k});
      u_m.xfer(w[i][7:0], 1'b1, r, k);
      note(96'h0, {95'h0, k});
      model(w[i]);
    end
    u_m.stop();
    note(live, swState);
  endtask : wr

  // Read transfer of n bytes, last one not acknowledged
  task automatic rd(input int n);
    logic [7:0] r;
    logic k;
    u_m.start();
    u_m.xfer({4'hE, addrSelPin, 1'b1}, 1'b1, r, k);
    note(96'h0, {95'h0, k});
    for (int i = 0; i < n; i++)
    begin
      u_m.xfer(8'hFF, (i == n - 1), r, k);
      note({88'h0, live[swIdx(rbCode, 3'h0) +: 8]}, {88'h0, r});
    end
    u_m.stop();
  endtask : rd

  // Foreign address: no acknowledge, and silence until the next start
  task automatic probe(input logic [7:0] a);
    logic [7:0] r;
    logic k;
    u_m.start();
    u_m.xfer(a, 1'b1, r, k);
    note(96'h1, {95'h0, k});
    u_m.xfer(8'h00, 1'b1, r, k);
    note(96'h1, {95'h0, k});
    u_m.stop();
  endtask : probe

  // Print counts and verdict, then end the run
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // Checker: oldest expectation against each observed result
  initial
  forever
  begin
    @(obsEvt);
    expV = expQ.pop_front();
    `CHK(obs, expV)
  end

  // Watchdog against a hung transfer
  initial
  begin
    #3_000_000;
    failures++;
    close_out();
  end

  // Main sequence
  initial
  begin
    clkEn = 1'b1;
    rst_b = 1'b0;
    swResetPin_b = 1'b1;
    addrSelPin = 3'h0;
    pend = '0;
    live = '0;
    rbCode = 4'h0;
    void'($urandom(47));
    repeat (8) @(posedge clock);
    #2;
    rst_b = 1'b1;
    u_m.tick(6);
    note(96'h0, swState);
    rd(1);
    // Every address select value, foreign addresses and reserved rows among them
    for (int a = 0; a < 8; a++)
    begin
      addrSelPin = 3'(a);
      gap();
      probe({4'hE, 3'(a) ^ 3'h5, 1'b0});
      probe({4'h6, 3'(a), 1'b0});
      wr('{{1'b1, 4'(a), 3'(7 - a), 7'h0, 1'b1}});
    end
    // Two stored words, then one load word in its own transfer
    wr('{16'h9A00, 16'hC300});
    wr('{16'h1501});
    rd(3);
    wr('{16'hF101, 16'hF901});
    // Reset pin clears live and pending state, frozen while clock enable is low
    clkEn = 1'b0;
    swResetPin_b = 1'b0;
    u_m.tick(8);
    note(live, swState);
    clkEn = 1'b1;
    u_m.tick(8);
    note(96'h0, swState);
    pend = '0;
    live = '0;
    swResetPin_b = 1'b1;
    u_m.tick(6);
    wr('{16'hE001});
    // Random command words with a random address select
    addrSelPin = 3'($urandom);
    u_m.tick(6);
    repeat (12)
      wr('{16'($urandom)});
    rd(2);
    // Power-on reset again in mid-run
    rst_b = 1'b0;
    u_m.tick(2);
    note(96'h0, swState);
    rst_b = 1'b1;
    pend = '0;
    live = '0;
    rbCode = 4'h0;
    u_m.tick(6);
    rd(1);
    u_m.tick(4);
    close_out();
  end
endmodule : xps_ctrl_test
`default_nettype wire
